/* shared/pdp_params.svh */
// Purpose: Constants for the program and debug port register block
// Assumes: Eight-bit registers at a four-bit offset
// Notes:   Timing counts are in port clock cycles
`ifndef PDP_PARAMS_SVH
`define PDP_PARAMS_SVH

// --------------------------------------------------------------
// Offsets
// --------------------------------------------------------------
`define PDP_OFF_REV     4'h0
`define PDP_OFF_ERR     4'h1
`define PDP_OFF_CTLM    4'h2
`define PDP_OFF_CTLA    4'h3
`define PDP_OFF_KEY     4'h7
`define PDP_OFF_RST     4'h8
`define PDP_OFF_CLK     4'h9
`define PDP_OFF_SYSC    4'hA
`define PDP_OFF_SYSS    4'hB
`define PDP_OFF_CRC     4'hC

// --------------------------------------------------------------
// Field positions
// --------------------------------------------------------------
`define PDP_B_INTER_BYTE_DELAY_ENABLE     7
`define PDP_B_PARITY_CHECK_DISABLE      5
`define PDP_B_DTD       4
`define PDP_B_RSD       3
`define PDP_B_NACKD     4
`define PDP_B_CCDD      3
`define PDP_B_PDIS      2
`define PDP_B_UROW      5
`define PDP_B_PROG      4
`define PDP_B_ERASE     3
`define PDP_B_SYSTEM_CLOCK_REQUEST    0
`define PDP_B_UFINAL    1
`define PDP_B_RSTSYS    5
`define PDP_B_SLEEP     4
`define PDP_B_NVMP      3
`define PDP_B_UROWP     2
`define PDP_B_LOCK      0

// --------------------------------------------------------------
// Values
// --------------------------------------------------------------
`define PDP_RST_SIG     8'h59
`define PDP_CLKSEL_RST  2'h3
`define PDP_GT_OFF      3'h7
`define PDP_GT_MAX      8'h80
`define PDP_TIMEOUT     65536
`define PDP_IDLE_CHARS  2
`define PDP_CHAR_BITS   12
`define PDP_REV_DEF     4'h5

`endif

/* shared/pdp_pkg.sv */
// Purpose: Types for the program and debug port register block
// Assumes: Constants come from pdp_params.svh
// Notes:   Types only
package pdp_pkg;

    typedef enum logic [2:0] {
        ERR_NONE    = 3'b000,
        ERR_PARITY  = 3'b001,
        ERR_FRAME   = 3'b010,
        ERR_TIMEOUT = 3'b011,
        ERR_CLKREC  = 3'b100,
        ERR_CONTEND = 3'b111
    } pdp_err_type;

    typedef enum logic [1:0] {
        TX_IDLE  = 2'b00,
        TX_GUARD = 2'b01,
        TX_SEND  = 2'b10,
        TX_GAP   = 2'b11
    } pdp_tx_type;

endpackage

/* rtl/pdp_regs.sv */
// Purpose: Register set and physical-layer control of a single-wire debug port
// Assumes: Framing engine drives the event inputs on ref_clk; sleep and
//          lock inputs come from the system domain and are synchronised here
// Notes:   Registers reached only through the link's register instructions
//
// Functional notes
// - Port logic and its clock keep running in all sleep modes while enabled.
// - Deny system bus access when sleeping with processor clock off, no request.
// - Sleeping flag set in idle sleep or deeper, cleared otherwise.
// - Clock request one keeps system clock running; sleep only emulated.
// - Clock request bit resets to one.
// - Registers reachable only via link instructions, never by the processor.
// - Offsets 0x0-0x3 physical configuration, 0x4-0xC access layer.
// - Read-only four-bit revision in upper nibble of first status register.
// - Error signature loaded on internal error, cleared when debugger reads it.
// - Signatures: 0 none,1 parity,2 frame,3 timeout,4 clock recovery,7 contention.
// - Inter-byte delay inserts two idle characters; guard time before first byte.
// - Parity disable ignores parity bit and raises no parity error.
// - Unless disabled, flag timeout after 65536 cycles without access response.
// - Response signature disable suppresses all response signatures.
// - Guard time codes 0-6 give 128 down to 2 cycles; 7 none.
// - Negative acknowledge disable suppresses NACK on reset during load/store.
// - Collision detect disable stops contention detection and reporting.
// - Port disable turns interface off, drops clock request, resets settings, keys.
// - Key flags read-only: user row bit 5, programming 4, erase 3; code clears user row flag when bit 5 written as one.
// - Programming key flag clears when programming sequence finishes.
// - Erase key flag clears when chip erase completes.
// - Writing 0x59 to reset request asserts system reset; other values release.
`timescale 1ns/1ps
`include "pdp_params.svh"

module pdp_regs #(
    parameter int TIMEOUT_CYC = `PDP_TIMEOUT,
    parameter int CHAR_BITS   = `PDP_CHAR_BITS,
    parameter logic [3:0] REVISION = `PDP_REV_DEF  // Arbitrary value
) (
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic       clkEn,
    input  wire logic       regWr,
    input  wire logic       regRd,
    input  wire logic [3:0] regAddr,
    input  wire logic [7:0] regWdata,
    output logic      [7:0] regRdata,
    input  wire logic       parityErr,
    input  wire logic       frameErr,
    input  wire logic       startErr,
    input  wire logic       contention,
    input  wire logic       accReq,
    input  wire logic       accAck,
    input  wire logic       txStart,
    input  wire logic       txByteDone,
    input  wire logic       txLast,
    input  wire logic       respPending,
    input  wire logic       nackPending,
    input  wire logic       keyUrowSet,
    input  wire logic       keyProgSet,
    input  wire logic       keyEraseSet,
    input  wire logic       progDone,
    input  wire logic       eraseDone,
    input  wire logic       sysSleepIn,
    input  wire logic       cpuClkOffIn,
    input  wire logic       lockIn,
    input  wire logic       nvmProgIn,
    input  wire logic       urowProgIn,
    input  wire logic [2:0] crcIn,
    output logic            txAllowed,
    output logic            respEmit,
    output logic            nackEmit,
    output logic            busGrant,
    output logic            sysClkReq,
    output logic            sysRstReq,
    output logic            portEnabled,
    output logic            urowFinal,
    output logic [1:0]      portClkSel,
    output logic            parityCheckEn,
    output logic            contendDetEn
);
    import pdp_pkg::*;

    // --------------------------------------------------------------
    // State
    // --------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  rdata;
        logic [2:0]  errSig;
        logic [7:0]  ctlMain;
        logic [2:0]  ctlAux;
        logic        kUrow;
        logic        kProg;
        logic        kErase;
        logic        reset_request_value;
        logic [1:0]  clkSel;
        logic        system_clock_request;
        logic        uFinal;
        logic        rstSysSeen;
        logic [4:0]  syncA;
        logic [4:0]  syncB;
        logic [2:0]  crcA;
        logic [2:0]  crcB;
        logic        toBusy;
        logic [16:0] toCnt;
        pdp_tx_type  txSt;
        logic [7:0]  gtCnt;
        logic [7:0]  gapCnt;
        logic        txOk;
        logic        resp;
        logic        nack;
        logic        grant;
        logic        enabled;
        logic        parEn;
        logic        ccEn;
    } pdp_state_type;

    pdp_state_type cur_ff;
    pdp_state_type nxt_cur;

    logic       sleeping;
    logic       cpuOff;
    logic [7:0] gtLen;
    logic [4:0] syncIn;

    assign syncIn = {sysSleepIn, cpuClkOffIn, lockIn, nvmProgIn, urowProgIn};
    assign sleeping = cur_ff.syncB[4];
    assign cpuOff   = cur_ff.syncB[3];
    // Halving per code step
    assign gtLen = `PDP_GT_MAX >> cur_ff.ctlMain[2:0];

    // --------------------------------------------------------------
    // Next state
    // --------------------------------------------------------------
    always_comb begin
        nxt_cur = cur_ff;
        // Sync stage one feeds stage two only
        nxt_cur.syncA = syncIn;
        nxt_cur.syncB = cur_ff.syncA;
        nxt_cur.crcA  = crcIn;
        nxt_cur.crcB  = cur_ff.crcA;
        nxt_cur.rstSysSeen = cur_ff.rstSysSeen | cur_ff.reset_request_value;

        // Register reads, link side only
        if (regRd) begin
            unique case (regAddr)
                `PDP_OFF_REV:  nxt_cur.rdata = {REVISION, 4'h0};
                `PDP_OFF_ERR:  nxt_cur.rdata = {5'h00, cur_ff.errSig};
                `PDP_OFF_CTLM: nxt_cur.rdata = cur_ff.ctlMain;
                `PDP_OFF_CTLA: nxt_cur.rdata = {3'h0, cur_ff.ctlAux, 2'h0};
                `PDP_OFF_KEY:  nxt_cur.rdata = {2'h0, cur_ff.kUrow, cur_ff.kProg,
                                                cur_ff.kErase, 3'h0};
                `PDP_OFF_RST:  nxt_cur.rdata = {7'h00, cur_ff.reset_request_value};
                `PDP_OFF_CLK:  nxt_cur.rdata = {6'h00, cur_ff.clkSel};
                `PDP_OFF_SYSC: nxt_cur.rdata = {6'h00, cur_ff.uFinal, cur_ff.system_clock_request};
                `PDP_OFF_SYSS: nxt_cur.rdata = {2'h0, cur_ff.rstSysSeen, sleeping,
                                                cur_ff.syncB[1], cur_ff.syncB[0],
                                                1'b0, cur_ff.syncB[2]};
                `PDP_OFF_CRC:  nxt_cur.rdata = {5'h00, cur_ff.crcB};
                default:       nxt_cur.rdata = 8'h00;
            endcase
            if (regAddr == `PDP_OFF_ERR) begin
                nxt_cur.errSig = ERR_NONE;
            end
            if (regAddr == `PDP_OFF_SYSS) begin
                nxt_cur.rstSysSeen = cur_ff.reset_request_value;
            end
        end

        // Register writes
        if (regWr) begin
            unique case (regAddr)
                `PDP_OFF_CTLM: nxt_cur.ctlMain = regWdata & 8'hBF;
                `PDP_OFF_CTLA: nxt_cur.ctlAux = regWdata[4:2];
                `PDP_OFF_KEY:  if (regWdata[`PDP_B_UROW]) nxt_cur.kUrow = 1'b0;
                `PDP_OFF_RST:  nxt_cur.reset_request_value = (regWdata == `PDP_RST_SIG);
                `PDP_OFF_CLK:  nxt_cur.clkSel = regWdata[1:0];
                `PDP_OFF_SYSC: begin
                    nxt_cur.system_clock_request = regWdata[`PDP_B_SYSTEM_CLOCK_REQUEST];
                    if (cur_ff.kUrow) nxt_cur.uFinal = regWdata[`PDP_B_UFINAL];
                end
                default: ;
            endcase
        end

        // Key flags: set wins over done or write clear; a port disable below still clears them
        if (progDone)    nxt_cur.kProg  = 1'b0;
        if (eraseDone)   nxt_cur.kErase = 1'b0;
        if (keyUrowSet)  nxt_cur.kUrow  = 1'b1;
        if (keyProgSet)  nxt_cur.kProg  = 1'b1;
        if (keyEraseSet) nxt_cur.kErase = 1'b1;

        // Access-layer time-out
        if (accAck || cur_ff.ctlMain[`PDP_B_DTD]) begin
            nxt_cur.toBusy = 1'b0;
            nxt_cur.toCnt  = '0;
        end else if (accReq) begin
            nxt_cur.toBusy = 1'b1;
            nxt_cur.toCnt  = '0;
        end else if (cur_ff.toBusy) begin
            nxt_cur.toCnt = cur_ff.toCnt + 17'd1;
        end

        // Error signature, later load wins; a new error beats a read clear
        if (cur_ff.toBusy && cur_ff.toCnt == 17'(TIMEOUT_CYC - 1)) begin
            nxt_cur.errSig = ERR_TIMEOUT;
            nxt_cur.toBusy = 1'b0;
        end
        if (startErr) nxt_cur.errSig = ERR_CLKREC;
        if (frameErr) nxt_cur.errSig = ERR_FRAME;
        if (parityErr && !cur_ff.ctlMain[`PDP_B_PARITY_CHECK_DISABLE]) begin
            nxt_cur.errSig = ERR_PARITY;
        end
        if (contention && !cur_ff.ctlAux[1]) begin
            nxt_cur.errSig = ERR_CONTEND;
        end

        // Transmit pacing
        nxt_cur.txOk = 1'b0;
        unique case (cur_ff.txSt)
            TX_IDLE: if (txStart) begin
                if (cur_ff.ctlMain[2:0] == `PDP_GT_OFF) begin
                    nxt_cur.txSt = TX_SEND;
                    nxt_cur.txOk = 1'b1;
                end else begin
                    nxt_cur.txSt  = TX_GUARD;
                    nxt_cur.gtCnt = gtLen - 8'd1;
                end
            end
            TX_GUARD: if (cur_ff.gtCnt == 8'd0) begin
                nxt_cur.txSt = TX_SEND;
                nxt_cur.txOk = 1'b1;
            end else begin
                nxt_cur.gtCnt = cur_ff.gtCnt - 8'd1;
            end
            TX_SEND: begin
                nxt_cur.txOk = 1'b1;
                if (txByteDone && txLast) begin
                    nxt_cur.txSt = TX_IDLE;
                    nxt_cur.txOk = 1'b0;
                end else if (txByteDone && cur_ff.ctlMain[`PDP_B_INTER_BYTE_DELAY_ENABLE]) begin
                    // Two idle characters
                    nxt_cur.txSt   = TX_GAP;
                    nxt_cur.txOk   = 1'b0;
                    nxt_cur.gapCnt = 8'(`PDP_IDLE_CHARS * CHAR_BITS - 1);
                end
            end
            TX_GAP: if (cur_ff.gapCnt == 8'd0) begin
                nxt_cur.txSt = TX_SEND;
                nxt_cur.txOk = 1'b1;
            end else begin
                nxt_cur.gapCnt = cur_ff.gapCnt - 8'd1;
            end
        endcase

        nxt_cur.resp  = respPending && !cur_ff.ctlMain[`PDP_B_RSD];
        nxt_cur.nack  = nackPending && cur_ff.reset_request_value
                        && !cur_ff.ctlAux[2];
        // Bus lost only when cpu clock is off and nobody holds it on
        nxt_cur.grant = !(sleeping && cpuOff && !cur_ff.system_clock_request);
        // Sleep never gates the port; only a disable drops it, until rst
        nxt_cur.enabled = cur_ff.enabled;

        // Disable: back to reset settings, keys dropped, clock request low
        if (regWr && regAddr == `PDP_OFF_CTLA && regWdata[`PDP_B_PDIS]) begin
            nxt_cur.ctlMain = 8'h00;
            nxt_cur.ctlAux  = 3'h0;
            nxt_cur.kUrow   = 1'b0;
            nxt_cur.kProg   = 1'b0;
            nxt_cur.kErase  = 1'b0;
            nxt_cur.system_clock_request  = 1'b0;
            nxt_cur.uFinal  = 1'b0;
            nxt_cur.clkSel  = `PDP_CLKSEL_RST;
            nxt_cur.errSig  = ERR_NONE;
            nxt_cur.toBusy  = 1'b0;
            nxt_cur.txSt    = TX_IDLE;
            nxt_cur.txOk    = 1'b0;
            nxt_cur.enabled = 1'b0;
        end
        // Enables kept as flops so the outputs need no gate
        nxt_cur.parEn = !nxt_cur.ctlMain[`PDP_B_PARITY_CHECK_DISABLE];
        nxt_cur.ccEn  = !nxt_cur.ctlAux[1];
    end

    // --------------------------------------------------------------
    // Registers; system reset request never resets the port itself
    // --------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cur_ff        <= '0;
            cur_ff.system_clock_request <= 1'b1;
            cur_ff.clkSel <= `PDP_CLKSEL_RST;
            cur_ff.grant  <= 1'b1;
            cur_ff.enabled <= 1'b1;
            cur_ff.parEn  <= 1'b1;
            cur_ff.ccEn   <= 1'b1;
            cur_ff.txSt   <= TX_IDLE;
        end else if (clkEn) begin
            cur_ff <= nxt_cur;
        end
    end

    assign regRdata      = cur_ff.rdata;
    assign txAllowed     = cur_ff.txOk;
    assign respEmit      = cur_ff.resp;
    assign nackEmit      = cur_ff.nack;
    assign busGrant      = cur_ff.grant;
    assign sysClkReq     = cur_ff.system_clock_request;
    assign sysRstReq     = cur_ff.reset_request_value;
    assign portEnabled   = cur_ff.enabled;
    assign urowFinal     = cur_ff.uFinal;
    assign portClkSel    = cur_ff.clkSel;
    assign parityCheckEn = cur_ff.parEn;
    assign contendDetEn  = cur_ff.ccEn;
endmodule

/* verification/pdp_regs_monitor.sv */
// Purpose: Port-level assertions for pdp_regs
// Assumes: One ref_clk domain, rst asynchronous active high
// Notes:   Shadows two control registers to judge the outputs
`timescale 1ns/1ps
module pdp_regs_monitor (
    input wire logic       ref_clk,
    input wire logic       rst,
    input wire logic       clkEn,
    input wire logic       regWr,
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic       txStart,
    input wire logic       txAllowed,
    input wire logic       respEmit,
    input wire logic       nackEmit,
    input wire logic       busGrant,
    input wire logic       sysClkReq,
    input wire logic       sysRstReq,
    input wire logic       portEnabled,
    input wire logic [1:0] portClkSel,
    input wire logic       parityCheckEn,
    input wire logic       contendDetEn
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic [7:0] mainCtl_ff;
    logic [7:0] auxCtl_ff;
    logic       wrEn;
    assign wrEn = regWr && clkEn && portEnabled;
    // Port disable wipes settings, so the shadow follows it
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            mainCtl_ff <= 8'h00;
            auxCtl_ff <= 8'h00;
        end else if (wrEn && regAddr == 4'h3 && regWdata[2]) begin
            mainCtl_ff <= 8'h00;
            auxCtl_ff <= 8'h00;
        end else if (wrEn && regAddr == 4'h2) begin
            mainCtl_ff <= regWdata;
        end else if (wrEn && regAddr == 4'h3) begin
            auxCtl_ff <= regWdata;
        end
    end
    sequence gtOffSeq;
        txStart && clkEn && portEnabled && mainCtl_ff[2:0] == 3'h7;
    endsequence
    sequence gtTwoSeq;
        txStart && clkEn && portEnabled && mainCtl_ff[2:0] == 3'h6;
    endsequence
    rst_assert_a: assert property (wrEn && regAddr == 4'h8 && regWdata == 8'h59 |=> sysRstReq)
        else $error("reset request not raised");
    rst_release_a: assert property (wrEn && regAddr == 4'h8 && regWdata != 8'h59 |=> !sysRstReq)
        else $error("reset request not released");
    clk_req_a: assert property (wrEn && regAddr == 4'hA |=> sysClkReq == $past(regWdata[0]))
        else $error("clock request does not follow write");
    bus_keep_a: assert property (sysClkReq && $past(sysClkReq) |-> busGrant)
        else $error("bus denied while clock requested");
    port_off_a: assert property (wrEn && regAddr == 4'h3 && regWdata[2] |=> !portEnabled && !sysClkReq)
        else $error("port disable ignored");
    parity_en_a: assert property (wrEn && regAddr == 4'h2 |=> parityCheckEn == !$past(regWdata[5]))
        else $error("parity check enable wrong");
    collide_en_a: assert property (wrEn && regAddr == 4'h3 && !regWdata[2]
        |=> contendDetEn == !$past(regWdata[3]))
        else $error("contention detect enable wrong");
    clk_sel_a: assert property (wrEn && regAddr == 4'h9 |=> portClkSel == $past(regWdata[1:0]))
        else $error("clock select wrong");
    resp_off_a: assert property (mainCtl_ff[3] && $past(mainCtl_ff[3]) |-> !respEmit)
        else $error("response sent while disabled");
    nack_off_a: assert property (auxCtl_ff[4] && $past(auxCtl_ff[4]) |-> !nackEmit)
        else $error("negative ack sent while disabled");
    gt_off_a: assert property (gtOffSeq |-> ##[1:2] txAllowed)
        else $error("guard off still delays");
    gt_two_a: assert property (gtTwoSeq |=> !txAllowed ##[1:3] txAllowed)
        else $error("two cycle guard wrong");
endmodule
bind pdp_regs pdp_regs_monitor mon_u (.ref_clk(ref_clk), .rst(rst), .clkEn(clkEn),
    .regWr(regWr), .regAddr(regAddr), .regWdata(regWdata), .txStart(txStart),
    .txAllowed(txAllowed), .respEmit(respEmit), .nackEmit(nackEmit), .busGrant(busGrant),
    .sysClkReq(sysClkReq), .sysRstReq(sysRstReq), .portEnabled(portEnabled),
    .portClkSel(portClkSel), .parityCheckEn(parityCheckEn), .contendDetEn(contendDetEn));

/* verification/pdp_acc_model.sv */
// Purpose: Access layer stand-in that answers port requests
// Assumes: ackDelay 0 means no answer at all
// Notes:   Silence models a sleeping or reset system domain
`timescale 1ns/1ps
module pdp_acc_model (
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic       accReq,
    input  wire logic [7:0] ackDelay,
    output logic            accAck
);
    logic [7:0] cnt_ff;
    logic       busy_ff;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            busy_ff <= 1'b0;
            cnt_ff <= 8'h00;
            accAck <= 1'b0;
        end else begin
            accAck <= 1'b0;
            if (accReq) begin
                busy_ff <= 1'b1;
                cnt_ff <= 8'h01;
            end else if (busy_ff) begin
                cnt_ff <= cnt_ff + 8'h01;
                if (ackDelay != 8'h00 && cnt_ff == ackDelay) begin
                    accAck <= 1'b1;
                    busy_ff <= 1'b0;
                end
            end
        end
    end
endmodule

/* verification/testbench.sv */
// Purpose: Self-checking bench for pdp_regs
// Assumes: Time-out shortened to 64 cycles
// Notes:   Reads are checked one cycle after the strobe
`timescale 1ns/1ps
`include "pdp_params.svh"
module testbench;
    logic       ref_clk, rst, clkEn, regWr, regRd, accReq, accAck, txStart, respPending;
    logic       sysSleepIn, cpuClkOffIn, lockIn, nvmProgIn, urowProgIn;
    logic [3:0] regAddr, errIn;
    logic [7:0] regWdata, regRdata, rdData, ackDelay;
    logic [2:0] keySet, crcIn;
    logic [1:0] seqDone, portClkSel;
    logic       txAllowed, respEmit, nackEmit, busGrant, sysClkReq, sysRstReq, portEnabled;
    logic       parityCheckEn, contendDetEn;
    logic       txByteDone, txLast, nackPending, urowFinal;
    int         failCount, nTests;
    pdp_regs #(.TIMEOUT_CYC(64)) dut_u (.ref_clk(ref_clk), .rst(rst), .clkEn(clkEn),
        .regWr(regWr), .regRd(regRd), .regAddr(regAddr), .regWdata(regWdata),
        .regRdata(regRdata), .parityErr(errIn[0]), .frameErr(errIn[1]), .startErr(errIn[2]),
        .contention(errIn[3]), .accReq(accReq), .accAck(accAck), .txStart(txStart),
        .txByteDone(txByteDone), .txLast(txLast), .respPending(respPending),
        .nackPending(nackPending),
        .keyUrowSet(keySet[2]), .keyProgSet(keySet[1]), .keyEraseSet(keySet[0]),
        .progDone(seqDone[1]), .eraseDone(seqDone[0]), .sysSleepIn(sysSleepIn),
        .cpuClkOffIn(cpuClkOffIn), .lockIn(lockIn), .nvmProgIn(nvmProgIn),
        .urowProgIn(urowProgIn), .crcIn(crcIn), .txAllowed(txAllowed), .respEmit(respEmit),
        .nackEmit(nackEmit), .busGrant(busGrant), .sysClkReq(sysClkReq),
        .sysRstReq(sysRstReq), .portEnabled(portEnabled), .urowFinal(urowFinal),
        .portClkSel(portClkSel), .parityCheckEn(parityCheckEn), .contendDetEn(contendDetEn));
    pdp_acc_model acc_u (.ref_clk(ref_clk), .rst(rst), .accReq(accReq), .ackDelay(ackDelay),
        .accAck(accAck));
    always #25 ref_clk = ~ref_clk;
    // ----------------------------------------------------------
    // Bus and check tasks
    // ----------------------------------------------------------
    task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
        nTests++;
        if (got !== exp) begin
            failCount++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge ref_clk);
        regWr <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic rd(input logic [3:0] a);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge ref_clk);
        regRd <= 1'b0;
        @(posedge ref_clk);
        rdData = regRdata;
    endtask
    task automatic byteDone(input logic last);
        txByteDone <= 1'b1;
        txLast <= last;
        @(posedge ref_clk);
        txByteDone <= 1'b0;
        txLast <= 1'b0;
    endtask
    task automatic waitTx(output int n);
        n = 0;
        while (txAllowed !== 1'b1 && n < 300) begin
            @(posedge ref_clk);
            n++;
        end
    endtask
    task automatic pulseErr(input int i);
        errIn[i] <= 1'b1;
        @(posedge ref_clk);
        errIn <= 4'h0;
        @(posedge ref_clk);
    endtask
    task automatic reqWait(input logic [7:0] dly, input logic [7:0] exp);
        ackDelay <= dly;
        accReq <= 1'b1;
        @(posedge ref_clk);
        accReq <= 1'b0;
        repeat (80) @(posedge ref_clk);
        rd(4'h1);
        chk("timeout", rdData, exp);
    endtask
    task automatic reportAndStop();
        $display("checks %0d mismatches %0d", nTests, failCount);
        if (failCount == 0 && nTests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // ----------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------
    task automatic tResetValues();
        rd(4'h0);
        chk("revision", rdData, {`PDP_REV_DEF, 4'h0});
        wr(4'h0, 8'hFF);
        rd(4'h0);
        chk("revision ro", rdData, {`PDP_REV_DEF, 4'h0});
        rd(4'hA);
        chk("system_clock_request reset", rdData, 8'h01);
        rd(4'h4);
        chk("reserved", rdData, 8'h00);
    endtask
    task automatic tErrors();
        logic [7:0] codes [4] = '{8'h01, 8'h02, 8'h04, 8'h07};
        for (int i = 0; i < 4; i++) begin
            pulseErr(i);
            rd(4'h1);
            chk("error sig", rdData, codes[i]);
            rd(4'h1);
            chk("error clear", rdData, 8'h00);
        end
        clkEn <= 1'b0;
        pulseErr(1);
        clkEn <= 1'b1;
        wr(4'h2, 8'h20);
        pulseErr(0);
        rd(4'h1);
        chk("parity off", rdData, 8'h00);
        wr(4'h3, 8'h08);
        pulseErr(3);
        rd(4'h1);
        chk("contention off", rdData, 8'h00);
        wr(4'h2, 8'h00);
        wr(4'h3, 8'h00);
        reqWait(8'h05, 8'h00);
        reqWait(8'h00, 8'h03);
        wr(4'h2, 8'h10);
        reqWait(8'h00, 8'h00);
    endtask
    task automatic tGuard();
        int g;
        int n;
        for (int c = 0; c < 8; c++) begin
            g = (c == 7) ? 0 : (128 >> c);
            wr(4'h2, 8'(c));
            txStart <= 1'b1;
            @(posedge ref_clk);
            txStart <= 1'b0;
            waitTx(n);
            chk("guard time", 8'(n), 8'(g + 1));
            byteDone(1'b1);
        end
        wr(4'h2, 8'h87);
        txStart <= 1'b1;
        @(posedge ref_clk);
        txStart <= 1'b0;
        @(posedge ref_clk);
        byteDone(1'b0);
        @(posedge ref_clk);
        waitTx(n);
        chk("byte gap", 8'(n), 8'(`PDP_IDLE_CHARS * `PDP_CHAR_BITS));
        byteDone(1'b1);
        respPending <= 1'b1;
        repeat (2) @(posedge ref_clk);
        chk("resp on", {7'h0, respEmit}, 8'h01);
        wr(4'h2, 8'h08);
        repeat (3) @(posedge ref_clk);
        chk("resp off", {7'h0, respEmit}, 8'h00);
    endtask
    task automatic tResetReq();
        nackPending <= 1'b1;
        wr(4'h8, 8'h59);
        chk("sys reset", {7'h0, sysRstReq}, 8'h01);
        rd(4'h8);
        chk("reset read", rdData, 8'h01);
        chk("nack on", {7'h0, nackEmit}, 8'h01);
        wr(4'h3, 8'h10);
        @(posedge ref_clk);
        chk("nack off", {7'h0, nackEmit}, 8'h00);
        wr(4'h8, 8'h58);
        chk("sys release", {7'h0, sysRstReq}, 8'h00);
    endtask
    task automatic tKeys();
        keySet <= 3'h7;
        @(posedge ref_clk);
        keySet <= 3'h0;
        rd(4'h7);
        chk("keys", rdData, 8'h38);
        wr(4'hA, 8'h03);
        chk("urow final", {7'h0, urowFinal}, 8'h01);
        seqDone <= 2'h2;
        @(posedge ref_clk);
        seqDone <= 2'h1;
        @(posedge ref_clk);
        seqDone <= 2'h0;
        rd(4'h7);
        chk("keys done", rdData, 8'h20);
        wr(4'h7, 8'h20);
        rd(4'h7);
        chk("urow clear", rdData, 8'h00);
    endtask
    task automatic tSleep();
        {sysSleepIn, cpuClkOffIn, lockIn, nvmProgIn, urowProgIn} <= 5'h1F;
        crcIn <= 3'h2;
        wr(4'hA, 8'h00);
        repeat (4) @(posedge ref_clk);
        chk("bus deny", {7'h0, busGrant}, 8'h00);
        rd(4'hB);
        chk("sys status", rdData, 8'h3D);
        rd(4'hC);
        chk("crc status", rdData, 8'h02);
        sysSleepIn <= 1'b0;
        wr(4'hA, 8'h01);
        repeat (3) @(posedge ref_clk);
        chk("bus grant", {7'h0, busGrant}, 8'h01);
        rd(4'hB);
        chk("awake", rdData, 8'h0D);
        keySet <= 3'h7;
        wr(4'h9, 8'h01);
        keySet <= 3'h0;
        wr(4'h3, 8'h04);
        repeat (2) @(posedge ref_clk);
        chk("disabled", {4'h0, portClkSel, portEnabled, sysClkReq}, 8'h0C);
        rd(4'h7);
        chk("keys off", rdData, 8'h00);
    endtask
    initial begin
        {ref_clk, clkEn, regWr, regRd, accReq, txStart, respPending} = '0;
        {sysSleepIn, cpuClkOffIn, lockIn, nvmProgIn, urowProgIn} = '0;
        {txByteDone, txLast, nackPending} = '0;
        {regAddr, errIn, regWdata, ackDelay, keySet, crcIn, seqDone} = '0;
        rst = 1'b1;
        clkEn = 1'b1;
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        tResetValues();
        tErrors();
        tGuard();
        tResetReq();
        tKeys();
        tSleep();
        reportAndStop();
    end
    // Whole run is under a thousand cycles; this leaves ample slack
    initial begin
        repeat (20000) @(posedge ref_clk);
        failCount++;
        reportAndStop();
    end
endmodule
